// File: include/gppi_pkg.sv
// =====================================================================
// Shared constants of the twelve-pin port with pin interrupts
package gppi_pkg;

    // =================================================================
    // Port geometry
    localparam int unsigned NUM_PINS      = 12;
    localparam logic [11:0] PINS_ALL      = 12'hfff;
    localparam logic [11:0] REG_RESET     = 12'h000;

    // =================================================================
    // Decode bases of the two port instances
    localparam logic [31:0] PORT0_BASE    = 32'h5000_0000;
    localparam logic [31:0] PORT1_BASE    = 32'h5001_0000;
    localparam int unsigned BASE_LSB      = 16;

    // =================================================================
    // Register offsets inside one port
    localparam logic [15:0] OFS_DATA_ALL  = 16'h3ffc;
    localparam logic [15:0] OFS_DIR       = 16'h8000;
    localparam logic [15:0] OFS_SENSE     = 16'h8004;
    localparam logic [15:0] OFS_DUAL      = 16'h8008;
    localparam logic [15:0] OFS_POL       = 16'h800c;
    localparam logic [15:0] OFS_MASK      = 16'h8010;
    localparam logic [15:0] OFS_RAW       = 16'h8014;
    localparam logic [15:0] OFS_MIS       = 16'h8018;
    localparam logic [15:0] OFS_CLR       = 16'h801c;

    // =================================================================
    // Field positions of the masked data window
    localparam int unsigned WIN_HI        = 15;
    localparam int unsigned WIN_LO        = 14;
    localparam logic [1:0]  WIN_DATA      = 2'h0;
    localparam int unsigned DMASK_HI      = 13;
    localparam int unsigned DMASK_LO      = 2;

    // =================================================================
    // Access size codes on the register port
    localparam logic [1:0]  SIZE_BYTE     = 2'h0;
    localparam logic [1:0]  SIZE_HALF     = 2'h1;
    localparam logic [1:0]  SIZE_WORD     = 2'h2;

endpackage : gppi_pkg

// File: sim/gppi_pin_model.sv
`timescale 1ns/10ps
// =====================================================================
// Far side of the port pins: port drive wins, then the outside source,
// else the pad pull-up holds a floating pin high
module gppi_pin_model (
    input  wire logic [11:0] i_pin_out,
    input  wire logic [11:0] i_pin_oe,
    input  wire logic [11:0] i_ext_val,
    input  wire logic [11:0] i_ext_en,
    output logic      [11:0] o_pin_level
);
    // Pull-up keeps an undriven pin defined, never a stale level
    always_comb begin
        for (int i = 0; i < 12; i++) begin
            if (i_pin_oe[i]) begin
                o_pin_level[i] = i_pin_out[i];
            end else if (i_ext_en[i]) begin
                o_pin_level[i] = i_ext_val[i];
            end else begin
                o_pin_level[i] = 1'b1;
            end
        end
    end
endmodule : gppi_pin_model

// File: sim/test_gppi_port.sv
`timescale 1ns/10ps
module test_gppi_port;
    localparam logic [31:0] P0 = gppi_pkg::PORT0_BASE;
    logic        i_core_clk  = 1'b0;
    logic        i_rst_b     = 1'b0;
    logic [31:0] i_bus_addr  = 32'h0000_0000;
    logic        i_bus_rd    = 1'b0;
    logic        i_bus_wr    = 1'b0;
    logic [1:0]  i_bus_size  = gppi_pkg::SIZE_WORD;
    logic [31:0] i_bus_wdata = 32'h0000_0000;
    logic [11:0] i_alt_func  = 12'h000;
    logic [11:0] ext_val     = 12'h000;
    logic [11:0] ext_en      = 12'h000;
    logic        clk_en      = 1'b1;
    logic [31:0] o_bus_rdata;
    logic        o_bus_ack;
    logic        o_bus_err;
    logic        o_port_irq;
    logic [11:0] i_pin_in;
    logic [11:0] o_pin_out;
    logic [11:0] o_pin_oe;
    int          errors      = 0;
    int          comparisons = 0;
    int          cycles      = 0;

    // =================================================================
    // Design, pins and clock
    gppi_port dut (.i_core_clk(i_core_clk), .i_rst_b(i_rst_b),
        .i_clk_en(clk_en), .i_bus_addr(i_bus_addr), .i_bus_rd(i_bus_rd),
        .i_bus_wr(i_bus_wr), .i_bus_size(i_bus_size),
        .i_bus_wdata(i_bus_wdata), .o_bus_rdata(o_bus_rdata),
        .o_bus_ack(o_bus_ack), .o_bus_err(o_bus_err),
        .i_pin_in(i_pin_in), .i_alt_func(i_alt_func),
        .o_pin_out(o_pin_out), .o_pin_oe(o_pin_oe),
        .o_port_irq(o_port_irq));
    gppi_pin_model pins (.i_pin_out(o_pin_out), .i_pin_oe(o_pin_oe),
        .i_ext_val(ext_val), .i_ext_en(ext_en), .o_pin_level(i_pin_in));
    always #4 i_core_clk = ~i_core_clk;

    // Cut a hang short
    always @(posedge i_core_clk) begin
        cycles++;
        if (cycles == 20000) begin
            errors++;
            close_out();
        end
    end

    // =================================================================
    // Shared tasks
    task automatic close_out;
        if (errors == 0 && comparisons > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : close_out

    task automatic check(input string nm, input logic [33:0] seen, exp);
        comparisons++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check

    task automatic tick;
        @(posedge i_core_clk);
        #1;
    endtask : tick

    // Synchroniser plus detector need five edges, the combined line six; eight leaves margin
    task automatic settle;
        repeat (8) tick();
    endtask : settle

    // One-cycle request pulse, answer sampled when ack shows
    task automatic bus(input logic wr, input logic [31:0] a,
                       input logic [31:0] wd, input logic [1:0] sz,
                       output logic [31:0] rd, output logic [1:0] ae);
        int n;
        n = 0;
        i_bus_addr  = a;
        i_bus_wr    = wr;
        i_bus_rd    = ~wr;
        i_bus_size  = sz;
        i_bus_wdata = wd;
        tick();
        i_bus_rd = 1'b0;
        i_bus_wr = 1'b0;
        while (o_bus_ack !== 1'b1 && n < 3) begin
            tick();
            n++;
        end
        rd = o_bus_rdata;
        ae = {o_bus_ack, o_bus_err};
        tick(); // Idle edge before the next request
    endtask : bus

    task automatic wreg(input logic [15:0] ofs, input logic [31:0] wd);
        logic [31:0] r;
        logic [1:0]  ae;
        bus(1'b1, P0 | ofs, wd, gppi_pkg::SIZE_WORD, r, ae);
    endtask : wreg

    // Read data and the ack/err pair judged together
    task automatic rreg(input string nm, input logic [15:0] ofs,
                        input logic [31:0] exp);
        logic [31:0] r;
        logic [1:0]  ae;
        bus(1'b0, P0 | ofs, 32'h0000_0000, gppi_pkg::SIZE_WORD, r, ae);
        check(nm, {ae, r}, {2'b10, exp});
    endtask : rreg

    // =================================================================
    // Scenarios
    task automatic regs_case;
        logic [31:0] r;
        logic [1:0]  ae;
        check("oe rst", o_pin_oe, 12'h000);
        rreg("dir rst", gppi_pkg::OFS_DIR, 0);
        for (int i = 0; i < 6; i++) begin
            rreg("cfg rst", gppi_pkg::OFS_SENSE + 16'(4 * i), 0);
        end
        wreg(gppi_pkg::OFS_RAW, 32'h0000_0fff);
        wreg(gppi_pkg::OFS_MIS, 32'h0000_0fff);
        rreg("raw ro", gppi_pkg::OFS_RAW, 0);
        rreg("mis ro", gppi_pkg::OFS_MIS, 0);
        rreg("clr wo", gppi_pkg::OFS_CLR, 0);
        // Upper bits of the write must not stick
        for (int i = 0; i < 4; i++) begin
            wreg(gppi_pkg::OFS_SENSE + 16'(4 * i), 32'hffff_fabc);
            rreg("cfg rw", gppi_pkg::OFS_SENSE + 16'(4 * i), 12'habc);
            wreg(gppi_pkg::OFS_SENSE + 16'(4 * i), 0);
        end
        rreg("rsv lo", 16'h4000, 0);
        rreg("rsv hi", 16'h8020, 0);
        bus(1'b0, P0 | gppi_pkg::OFS_DIR, 0, gppi_pkg::SIZE_BYTE, r, ae);
        check("byte", ae, 2'b11);
        bus(1'b0, P0 | 32'h8002, 0, gppi_pkg::SIZE_HALF, r, ae);
        check("unaligned", ae, 2'b11);
        bus(1'b0, gppi_pkg::PORT1_BASE | 32'h8000, 0,
            gppi_pkg::SIZE_WORD, r, ae);
        check("other base", ae, 2'b00);
        // Enable low: request ignored, state frozen
        clk_en = 1'b0;
        bus(1'b1, P0 | gppi_pkg::OFS_DIR, 32'h0000_0fff,
            gppi_pkg::SIZE_WORD, r, ae);
        check("frozen", {ae, o_pin_oe}, 14'h0000);
        clk_en = 1'b1;
        rreg("dir kept", gppi_pkg::OFS_DIR, 0);
    endtask : regs_case

    task automatic data_case;
        logic [31:0] r;
        logic [1:0]  ae;
        ext_en  = 12'hfff;
        ext_val = 12'ha5c;
        settle();
        rreg("pins", gppi_pkg::OFS_DATA_ALL, 12'ha5c);
        // Outside source released as the port takes over
        wreg(gppi_pkg::OFS_DIR, 12'h0ff);
        ext_en = 12'hf00;
        tick();
        check("oe", o_pin_oe, 12'h0ff);
        check("hold", o_pin_out & 12'h0ff, 12'h05c);
        wreg(gppi_pkg::OFS_DATA_ALL, 12'h0f0);
        tick();
        check("drive", o_pin_out & 12'h0ff, 12'h0f0);
        rreg("latch", gppi_pkg::OFS_DATA_ALL, 12'haf0);
        i_alt_func = 12'h080;
        ext_en     = 12'hf80;
        tick();
        check("alt oe", o_pin_oe, 12'h07f);
        settle();
        rreg("alt rd", gppi_pkg::OFS_DATA_ALL, 12'ha70);
        wreg(gppi_pkg::OFS_DATA_ALL, 12'h0ff);
        tick();
        check("alt wr", o_pin_oe, 12'h07f);
        tick();
        i_alt_func = 12'h000;
        ext_en     = 12'hf00;
        tick();
        check("alt back", o_pin_out & 12'h080, 12'h000);
        // Address bits 5:2 open data bits 3:0 only
        wreg(gppi_pkg::OFS_DATA_ALL, 0);
        bus(1'b1, P0 | 32'h003c, 32'h0000_0fff, gppi_pkg::SIZE_HALF, r, ae);
        tick();
        check("mask wr", o_pin_out & 12'h0ff, 12'h00f);
        rreg("mask rd", 16'h003c, 12'h00f);
        rreg("mask hi", 16'h3fc0, 12'ha00);
        rreg("mask none", 16'h0000, 0);
        ext_en = 12'hfcf;
        wreg(gppi_pkg::OFS_DIR, 12'h030);
        wreg(gppi_pkg::OFS_DATA_ALL, 0);
        tick();
        check("park", {o_pin_oe, o_pin_out & 12'h030}, 24'h03_0000);
    endtask : data_case

    // Pin 0 as input: step it from lo to hi under one trigger setting
    task automatic irq_case(input logic s, d, p, lo, hi, ex);
        ext_val[0] = lo;
        settle();
        wreg(gppi_pkg::OFS_SENSE, s);
        wreg(gppi_pkg::OFS_DUAL, d);
        wreg(gppi_pkg::OFS_POL, p);
        wreg(gppi_pkg::OFS_MASK, 1);
        // Earlier pin traffic leaves edges latched on other pins
        wreg(gppi_pkg::OFS_CLR, 32'h0000_0fff);
        settle();
        rreg("raw idle", gppi_pkg::OFS_RAW, 0);
        ext_val[0] = hi;
        settle();
        rreg("raw", gppi_pkg::OFS_RAW, ex);
        rreg("mis", gppi_pkg::OFS_MIS, ex);
        check("irq", o_port_irq, ex);
        wreg(gppi_pkg::OFS_MASK, 0);
        settle();
        rreg("mis off", gppi_pkg::OFS_MIS, 0);
        check("irq off", o_port_irq, 0);
        wreg(gppi_pkg::OFS_CLR, 1);
        tick();
        rreg("raw clr", gppi_pkg::OFS_RAW, ex & s);
    endtask : irq_case

    task automatic irq_all;
        wreg(gppi_pkg::OFS_DIR, 0);
        ext_en = 12'hfff;
        irq_case(0, 0, 1, 0, 1, 1);
        irq_case(0, 0, 1, 1, 0, 0);
        irq_case(0, 0, 0, 1, 0, 1);
        irq_case(0, 1, 0, 0, 1, 1);
        irq_case(0, 1, 1, 1, 0, 1);
        irq_case(1, 0, 1, 0, 1, 1);
        irq_case(1, 0, 0, 1, 0, 1);
    endtask : irq_all

    // =================================================================
    // Main sequence
    initial begin
        repeat (6) tick();
        i_rst_b = 1'b1;
        regs_case();
        data_case();
        irq_all();
        close_out();
    end
endmodule : test_gppi_port

// File: src/gppi_irq_detect.sv
`timescale 1ns/10ps
// =====================================================================
// Per-pin edge or level interrupt detection
module gppi_irq_detect #(
    parameter int unsigned W = gppi_pkg::NUM_PINS
) (
    input  wire logic         i_core_clk,
    input  wire logic         i_rst_b,
    input  wire logic         i_clk_en,
    input  wire logic [W-1:0] i_level,
    input  wire logic [W-1:0] i_prev,
    input  wire logic [W-1:0] i_sense,
    input  wire logic [W-1:0] i_dual,
    input  wire logic [W-1:0] i_pol,
    input  wire logic [W-1:0] i_clear,
    output logic      [W-1:0] o_raw
);

    typedef struct packed {
        logic [W-1:0] raw;
    } gppi_irq_s;

    gppi_irq_s    st_q;
    gppi_irq_s    st_d;
    logic [W-1:0] hit;
    logic [W-1:0] act;

    // Edge choice and level choice for every pin
    for (genvar g = 0; g < W; g++) begin : g_pin
        logic rise;
        logic fall;
        assign rise   = i_level[g] & ~i_prev[g];
        assign fall   = ~i_level[g] & i_prev[g];
        assign hit[g] = i_dual[g] ? (rise | fall)
                      : (i_pol[g] ? rise : fall);
        assign act[g] = i_pol[g] ? i_level[g] : ~i_level[g];
    end

    // Edge status sticks until cleared, a new edge beats the clear
    always_comb begin
        st_d     = st_q;
        st_d.raw = (i_sense & act)
                 | (~i_sense & (hit | (st_q.raw & ~i_clear)));
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_b) begin
            st_q <= '0;
        end else if (i_clk_en) begin
            st_q <= st_d;
        end
    end

    assign o_raw = st_q.raw;

    edge_sticky_a: assert property (@(posedge i_core_clk)
        disable iff (!i_rst_b)
        $past(i_clk_en) |-> (($past(st_q.raw) & ~$past(i_sense)
            & ~$past(i_clear) & ~st_q.raw) == '0))
        else $error("edge status dropped without a clear");

    level_follow_a: assert property (@(posedge i_core_clk)
        disable iff (!i_rst_b)
        $past(i_clk_en) |-> ((st_q.raw ^ $past(act))
            & $past(i_sense)) == '0)
        else $error("level status does not follow active level");

endmodule : gppi_irq_detect

// File: src/gppi_pin_sync.sv
`timescale 1ns/10ps
// =====================================================================
// Three-stage pin synchroniser with agreement filter
module gppi_pin_sync #(
    parameter int unsigned W = gppi_pkg::NUM_PINS
) (
    input  wire logic         i_core_clk,
    input  wire logic         i_rst_b,
    input  wire logic         i_clk_en,
    input  wire logic [W-1:0] i_async,
    output logic      [W-1:0] o_level,
    output logic      [W-1:0] o_prev
);

    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] lvl;
        logic [W-1:0] prev;
    } gppi_sync_s;

    gppi_sync_s st_q;
    gppi_sync_s st_d;

    // Level only moves once stages two and three agree
    always_comb begin
        st_d      = st_q;
        st_d.s1   = i_async;
        st_d.s2   = st_q.s1;
        st_d.s3   = st_q.s2;
        st_d.lvl  = (st_q.s2 & st_q.s3) | (st_q.lvl & (st_q.s2 ^ st_q.s3));
        st_d.prev = st_q.lvl;
    end

    // Constant reset; clock enable freezes every stage
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_b) begin
            st_q <= '0;
        end else if (i_clk_en) begin
            st_q <= st_d;
        end
    end

    assign o_level = st_q.lvl;
    assign o_prev  = st_q.prev;

    filter_agree_a: assert property (@(posedge i_core_clk)
        disable iff (!i_rst_b)
        $past(i_clk_en) |-> ((st_q.lvl ^ $past(st_q.lvl))
            & ~($past(st_q.s2) ~^ $past(st_q.s3))) == '0)
        else $error("level moved while stages disagreed");

endmodule : gppi_pin_sync

// File: src/gppi_port.sv
`timescale 1ns/10ps
// =====================================================================
// Overview of operation
// - Direction bit zero input, one output.
// - Direction register resets to all inputs.
// - Data read returns live pin levels on non-output pins.
// - Output pins drive the data latch.
// - Input pins ignore data writes, read pin.
// - Alternate function pins ignore writes, read pin.
// - Output pins read back the latch.
// - Latch tracks pin until switched to output.
// - Address bits 13 to 2 mask data.
// - Word or half-word at word addresses.
// - Absent pin bits behave as reserved.
// - Decode port base, reserved ranges answer zero.
// - Each pin raises edge or level interrupt.
// - Edges select rising, falling or both.
// - Levels select high or low active.
// - Sense, dual, polarity, mask registers read-write.
// - Raw and masked status read-only, reset zero.
// - Clear register is write-only.
// - Sense zero edge, sense one level.
// - Dual edge bit overrides polarity choice.
// - Polarity zero falling/low, one rising/high.
// - Mask one passes pin to combined line.
module gppi_port #(
    parameter logic [31:0] BASE_ADDR   = gppi_pkg::PORT0_BASE,
    parameter logic [11:0] PIN_PRESENT = gppi_pkg::PINS_ALL
) (
    input  wire logic        i_core_clk,
    input  wire logic        i_rst_b,
    input  wire logic        i_clk_en,
    input  wire logic [31:0] i_bus_addr,
    input  wire logic        i_bus_rd,
    input  wire logic        i_bus_wr,
    input  wire logic [1:0]  i_bus_size,
    input  wire logic [31:0] i_bus_wdata,
    output logic      [31:0] o_bus_rdata,
    output logic             o_bus_ack,
    output logic             o_bus_err,
    input  wire logic [11:0] i_pin_in,
    input  wire logic [11:0] i_alt_func,
    output logic      [11:0] o_pin_out,
    output logic      [11:0] o_pin_oe,
    output logic             o_port_irq
);

    // =================================================================
    // State
    typedef struct packed {
        logic [11:0] dir;
        logic [11:0] sense;
        logic [11:0] dual;
        logic [11:0] pol;
        logic [11:0] mask;
        logic [11:0] latch;
        logic [11:0] oe;
        logic        irq;
        logic        ack;
        logic        err;
        logic [31:0] rdata;
    } gppi_port_s;

    gppi_port_s  st_q;
    gppi_port_s  st_d;

    logic [11:0] pin_lvl;
    logic [11:0] pin_prev;
    logic [11:0] raw;
    logic [11:0] clr;
    logic [15:0] ofs;
    logic        hit;
    logic        req;
    logic        size_ok;
    logic        win;
    logic        wr_ok;
    logic        rd_ok;
    logic        wr_dat;
    logic [11:0] dmask;
    logic [11:0] wmask;
    logic [11:0] is_out;
    logic [11:0] pin_view;
    logic [11:0] wdat;

    // =================================================================
    // Pin synchroniser and interrupt detection
    gppi_pin_sync #(
        .W (gppi_pkg::NUM_PINS)
    ) u_sync (
        .i_core_clk (i_core_clk),
        .i_rst_b    (i_rst_b),
        .i_clk_en   (i_clk_en),
        .i_async    (i_pin_in),
        .o_level    (pin_lvl),
        .o_prev     (pin_prev)
    );

    gppi_irq_detect #(
        .W (gppi_pkg::NUM_PINS)
    ) u_irq (
        .i_core_clk (i_core_clk),
        .i_rst_b    (i_rst_b),
        .i_clk_en   (i_clk_en),
        .i_level    (pin_lvl),
        .i_prev     (pin_prev),
        .i_sense    (st_q.sense),
        .i_dual     (st_q.dual),
        .i_pol      (st_q.pol),
        .i_clear    (clr),
        .o_raw      (raw)
    );

    // =================================================================
    // Address decode
    // Only the upper half-word selects the port; low half is the offset
    assign ofs     = i_bus_addr[15:0];
    assign hit     = i_bus_addr[31:gppi_pkg::BASE_LSB]
                     == BASE_ADDR[31:gppi_pkg::BASE_LSB];
    assign req     = hit & (i_bus_rd | i_bus_wr);
    // Byte lanes are not supported, nor unaligned words
    assign size_ok = (i_bus_size == gppi_pkg::SIZE_HALF
                      || i_bus_size == gppi_pkg::SIZE_WORD)
                     && i_bus_addr[1:0] == 2'h0;
    assign wr_ok   = req & size_ok & i_bus_wr;
    assign rd_ok   = req & size_ok & ~i_bus_wr;
    assign win     = ofs[gppi_pkg::WIN_HI:gppi_pkg::WIN_LO]
                     == gppi_pkg::WIN_DATA;
    assign dmask   = win ? ofs[gppi_pkg::DMASK_HI:gppi_pkg::DMASK_LO]
                         : 12'h000;
    assign wmask   = dmask & PIN_PRESENT;
    assign wr_dat  = wr_ok & win;
    assign wdat    = i_bus_wdata[11:0] & PIN_PRESENT;

    // Clear pulse reaches the detector in the write cycle itself
    assign clr     = (wr_ok && ofs == gppi_pkg::OFS_CLR) ? wdat
                                                        : 12'h000;

    // =================================================================
    // Pin view: output pins show the latch, all others the live pin
    assign is_out   = st_q.dir & ~i_alt_func & PIN_PRESENT;
    assign pin_view = (st_q.latch & is_out)
                    | (pin_lvl & ~is_out);

    // =================================================================
    // Next state: registers, latch, pin drive, read data
    always_comb begin
        st_d       = st_q;
        st_d.ack   = 1'b0;
        st_d.err   = 1'b0;
        st_d.rdata = 32'h0000_0000;

        // Latch mirrors the pin so a later switch keeps its level
        st_d.latch = pin_view;

        if (wr_ok) begin
            if (win) begin
                st_d.latch = (pin_view & ~wmask) | (wdat & wmask);
            end else begin
                unique case (ofs)
                    gppi_pkg::OFS_DIR:   st_d.dir   = wdat;
                    gppi_pkg::OFS_SENSE: st_d.sense = wdat;
                    gppi_pkg::OFS_DUAL:  st_d.dual  = wdat;
                    gppi_pkg::OFS_POL:   st_d.pol   = wdat;
                    gppi_pkg::OFS_MASK:  st_d.mask  = wdat;
                    default: begin
                        // Status, clear and reserved keep all state
                        st_d.dir = st_q.dir;
                    end
                endcase
            end
        end

        if (rd_ok) begin
            if (win) begin
                st_d.rdata[11:0] = pin_view & dmask & PIN_PRESENT;
            end else begin
                unique case (ofs)
                    gppi_pkg::OFS_DIR:   st_d.rdata[11:0] = st_q.dir;
                    gppi_pkg::OFS_SENSE: st_d.rdata[11:0] = st_q.sense;
                    gppi_pkg::OFS_DUAL:  st_d.rdata[11:0] = st_q.dual;
                    gppi_pkg::OFS_POL:   st_d.rdata[11:0] = st_q.pol;
                    gppi_pkg::OFS_MASK:  st_d.rdata[11:0] = st_q.mask;
                    gppi_pkg::OFS_RAW: begin
                        st_d.rdata[11:0] = raw & PIN_PRESENT;
                    end
                    gppi_pkg::OFS_MIS: begin
                        st_d.rdata[11:0] = raw & st_q.mask;
                    end
                    default: begin
                        // Clear and reserved offsets read as zero
                        st_d.rdata = 32'h0000_0000;
                    end
                endcase
            end
        end

        // Every decoded request taken with the enable high is answered; bad sizes flag an error
        st_d.ack = req;
        st_d.err = req & ~size_ok;

        // Pad drive follows the new direction, mux choice from outside
        st_d.oe  = st_d.dir & ~i_alt_func & PIN_PRESENT;
        st_d.irq = |(raw & st_q.mask);
    end

    // =================================================================
    // State register; all pins inputs after reset
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_b) begin
            st_q       <= '0;
            st_q.dir   <= gppi_pkg::REG_RESET;
            st_q.sense <= gppi_pkg::REG_RESET;
            st_q.dual  <= gppi_pkg::REG_RESET;
            st_q.pol   <= gppi_pkg::REG_RESET;
            st_q.mask  <= gppi_pkg::REG_RESET;
        end else if (i_clk_en) begin
            st_q <= st_d;
        end
    end

    // =================================================================
    // Outputs straight from the state register
    assign o_bus_rdata = st_q.rdata;
    assign o_bus_ack   = st_q.ack;
    assign o_bus_err   = st_q.err;
    assign o_pin_out   = st_q.latch;
    assign o_pin_oe    = st_q.oe;
    assign o_port_irq  = st_q.irq;

    // =================================================================
    // Checks
    dir_reset_zero_a: assert property (@(posedge i_core_clk)
        disable iff (!i_rst_b)
        !$past(i_rst_b) |-> (st_q.dir == 12'h000 && o_pin_oe == 12'h000))
        else $error("pins not inputs after reset");

    oe_from_dir_a: assert property (@(posedge i_core_clk)
        disable iff (!i_rst_b)
        ($past(i_clk_en) && !$past(wr_ok)) |->
            o_pin_oe == ($past(st_q.dir) & ~$past(i_alt_func)
                         & PIN_PRESENT))
        else $error("pad enable differs from direction");

    latch_mirror_a: assert property (@(posedge i_core_clk)
        disable iff (!i_rst_b)
        ($past(i_clk_en) && !$past(wr_dat)) |->
            ((o_pin_out ^ $past(pin_lvl)) & ~$past(is_out)) == 12'h000)
        else $error("latch did not track non-output pin");

    out_hold_a: assert property (@(posedge i_core_clk)
        disable iff (!i_rst_b)
        ($past(i_clk_en) && !$past(wr_dat)) |->
            ((o_pin_out ^ $past(o_pin_out)) & $past(is_out)) == 12'h000)
        else $error("output latch changed without a write");

    masked_read_a: assert property (@(posedge i_core_clk)
        disable iff (!i_rst_b)
        ($past(i_clk_en) && $past(rd_ok) && $past(win)) |->
            (o_bus_rdata & ~{20'h0_0000, $past(dmask) & PIN_PRESENT})
            == 32'h0000_0000)
        else $error("masked-off data bit read nonzero");

    bad_size_err_a: assert property (@(posedge i_core_clk)
        disable iff (!i_rst_b)
        (i_clk_en && req && i_bus_size == gppi_pkg::SIZE_BYTE)
            |=> (o_bus_ack && o_bus_err))
        else $error("byte access not flagged");

    irq_combine_a: assert property (@(posedge i_core_clk)
        disable iff (!i_rst_b)
        $past(i_clk_en) |-> o_port_irq == |($past(raw) & $past(st_q.mask)))
        else $error("combined line is not OR of masked status");

    mask_blocks_a: assert property (@(posedge i_core_clk)
        disable iff (!i_rst_b)
        (st_q.mask == 12'h000)[*2] |-> !o_port_irq)
        else $error("masked port raised interrupt");

    clear_reads_zero_a: assert property (@(posedge i_core_clk)
        disable iff (!i_rst_b)
        (i_clk_en && rd_ok && ofs == gppi_pkg::OFS_CLR)
            |=> o_bus_rdata == 32'h0000_0000)
        else $error("clear register read nonzero");

    // =================================================================
    // Bus answer checks
    // Every decoded request with the enable high answered one edge later
    req_acked_a: assert property (@(posedge i_core_clk)
        disable iff (!i_rst_b)
        (i_clk_en && req) |=> o_bus_ack)
        else $error("decoded request not answered");

    // Foreign addresses leave the bus quiet
    foreign_quiet_a: assert property (@(posedge i_core_clk)
        disable iff (!i_rst_b)
        (i_clk_en && !hit) |=> !o_bus_ack)
        else $error("foreign address answered");

    // Error only ever rides on an answer
    err_with_ack_a: assert property (@(posedge i_core_clk)
        disable iff (!i_rst_b)
        o_bus_err |-> o_bus_ack)
        else $error("error flagged without answer");

    // Absent pins and upper bits never show in read data
    rdata_width_a: assert property (@(posedge i_core_clk)
        disable iff (!i_rst_b)
        (o_bus_rdata & ~{20'h0_0000, PIN_PRESENT}) == 32'h0000_0000)
        else $error("read data outside present pins");

    // Direction write lands whole on the next edge
    dir_write_a: assert property (@(posedge i_core_clk)
        disable iff (!i_rst_b)
        (i_clk_en && wr_ok && ofs == gppi_pkg::OFS_DIR)
            |=> st_q.dir == $past(wdat))
        else $error("direction write lost");

    // Clear pulse only from the clear offset
    clear_source_a: assert property (@(posedge i_core_clk)
        disable iff (!i_rst_b)
        (clr != 12'h000) |-> (wr_ok && ofs == gppi_pkg::OFS_CLR))
        else $error("clear pulse from another offset");

    // =================================================================
    // Pin drive checks
    // Mux owns alternate-function pins, never the port
    alt_no_drive_a: assert property (@(posedge i_core_clk)
        disable iff (!i_rst_b)
        $past(i_clk_en) |-> (o_pin_oe & $past(i_alt_func)) == 12'h000)
        else $error("port drives an alternate-function pin");

    // Window write reaches every enabled bit
    window_write_a: assert property (@(posedge i_core_clk)
        disable iff (!i_rst_b)
        (i_clk_en && wr_dat)
            |=> ((o_pin_out ^ $past(wdat)) & $past(wmask)) == 12'h000)
        else $error("window write missed an enabled bit");

    // Output pins read back the latch, not the pad
    out_read_a: assert property (@(posedge i_core_clk)
        disable iff (!i_rst_b)
        ($past(i_clk_en) && $past(rd_ok) && $past(win)) |->
            ((o_bus_rdata[11:0] ^ $past(st_q.latch))
             & $past(is_out & dmask)) == 12'h000)
        else $error("output pin read did not return the latch");

endmodule : gppi_port
